/* src/snoop_defs.svh */
// Constants for the data cache bus snoop logic.
// Assumes inclusion by bare name from the package and the snoop modules.
`ifndef SNOOP_DEFS_SVH
`define SNOOP_DEFS_SVH
`define SNP_ADDR_W 32
`define SNP_LINE_OFS 5
`define SNP_PAR_W 4
`define SNP_BYTE_W 8
`define SNP_TT_W 5
`define SNP_TT_CLEAN 5'h00
`define SNP_TT_FLUSH 5'h04
`define SNP_TT_SYNC 5'h08
`define SNP_TT_KILL 5'h0c
`define SNP_TT_BARRIER 5'h10
`define SNP_TT_ECOWX 5'h14
`define SNP_TT_ECIWX 5'h1c
`define SNP_TT_TLBIE 5'h18
`define SNP_TT_RSV_SET 5'h01
`define SNP_TT_TLBSYNC 5'h09
`define SNP_TT_ICBI 5'h0d
`define SNP_TT_WRITE_BIT 1
`define SNP_TT_READ_BIT 3
`define SNP_TT_ADDR_ONLY_BIT 0
`define SNP_TT_KIND_BIT 2
`endif

/* src/snoop_pkg.sv */
// Types shared by the data cache bus snoop logic.
// Assumes snoop_defs.svh is on the include path.
`include "snoop_defs.svh"
package snoop_pkg;
    typedef logic [`SNP_ADDR_W-1:0] addr_t;
    typedef logic [`SNP_TT_W-1:0] ttype_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOOKUP = 3'b010,
        ST_RESPOND = 3'b100
    } snoop_state_e;
    typedef enum logic [1:0] {
        ACT_NONE = 2'h0,
        ACT_PUSH = 2'h1,
        ACT_INVAL = 2'h2
    } snoop_act_e;
endpackage : snoop_pkg

/* src/snoop_line_match.sv */
// Compares a snooped address against a set of line addresses at line granularity.
// Assumes entries arrive packed, one line address per slot, with a valid bit each.
`timescale 1ns/10ps
`include "snoop_defs.svh"
module snoop_line_match #(
    parameter int ENTRIES = 4
) (
    input wire logic [`SNP_ADDR_W-1:0] snoop_addr,
    input wire logic [ENTRIES*`SNP_ADDR_W-1:0] line_addr,
    input wire logic [ENTRIES-1:0] line_valid,
    output logic hit
);
    logic [ENTRIES-1:0] match;
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_cmp
            // Low offset bits ignored: any byte of the 32-byte line collides
            assign match[g] = line_valid[g] &&
                (line_addr[g*`SNP_ADDR_W+`SNP_LINE_OFS +: `SNP_ADDR_W-`SNP_LINE_OFS] ==
                 snoop_addr[`SNP_ADDR_W-1:`SNP_LINE_OFS]);
        end
    endgenerate
    assign hit = |match;
endmodule : snoop_line_match

/* src/snoop_ctrl.sv */
// Data cache bus snoop control: qualification, parity check, tag and queue compare, retry.
// Assumes one bus clock, synchronous bus inputs, cache tag lookups answer combinationally
// in the cycle after the snoop is captured, and the cache acts on the forwarded action.
`timescale 1ns/10ps
`include "snoop_defs.svh"
module snoop_ctrl
    import snoop_pkg::*;
#(
    parameter int FILL_ENTRIES = 2,
    parameter int QUEUE_ENTRIES = 4
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic TRANSFER_START_N,
    input wire logic GLOBAL_COHERENT_N,
    input wire logic ADDRESS_BUS_BUSY_N,
    input wire logic BURST_INDICATION_N,
    input wire logic [`SNP_TT_W-1:0] TRANSFER_TYPE,
    input wire logic [`SNP_ADDR_W-1:0] ADDR,
    input wire logic [3:0] ADDR_PARITY,
    input wire logic OWN_TENURE,
    input wire logic SNOOP_BUSY,
    input wire logic RSV_VALID,
    input wire logic [`SNP_ADDR_W-1:0] RSV_ADDR,
    input wire logic L1_HIT,
    input wire logic L1_MODIFIED,
    input wire logic L2_HIT,
    input wire logic L2_MODIFIED,
    input wire logic [FILL_ENTRIES*`SNP_ADDR_W-1:0] FILL_ADDR,
    input wire logic [FILL_ENTRIES-1:0] FILL_VALID,
    input wire logic [QUEUE_ENTRIES*`SNP_ADDR_W-1:0] QUEUE_ADDR,
    input wire logic [QUEUE_ENTRIES-1:0] QUEUE_PENDING,
    output logic [`SNP_ADDR_W-1:0] LOOKUP_ADDR,
    output logic L1_LOOKUP,
    output logic L2_LOOKUP,
    output logic ADDRESS_RETRY_N,
    output logic [1:0] CACHE_ACTION,
    output logic CACHE_ACTION_VALID,
    output logic RSV_CLEAR,
    output logic PARITY_ERROR
);
    snoop_state_e state;
    snoop_state_e next_state;
    ttype_t snp_tt;
    logic snp_single;
    logic snp_busy;
    logic fill_hit;
    logic queue_hit;
    logic start;
    logic tt_write_kill;
    logic qualified;
    logic parity_bad;
    logic is_kill;
    logic is_read;
    logic cache_hit;
    logic cache_mod;
    logic no_action;
    logic want_retry;
    logic [1:0] next_action;

    assign start = !TRANSFER_START_N && !OWN_TENURE;
    // Kill carries the read bit, so it is matched whole; writes have the data bit with read bit clear
    assign tt_write_kill = TRANSFER_TYPE == `SNP_TT_KILL ||
        (!TRANSFER_TYPE[`SNP_TT_READ_BIT] && !TRANSFER_TYPE[`SNP_TT_ADDR_ONLY_BIT] &&
         TRANSFER_TYPE[`SNP_TT_WRITE_BIT]);
    // Bus-busy input is deliberately not read here
    assign qualified = start && (!GLOBAL_COHERENT_N || (RSV_VALID && tt_write_kill));

    always_comb begin
        parity_bad = 1'b0;
        for (int b = 0; b < `SNP_PAR_W; b++) begin
            parity_bad = parity_bad | (^{ADDR[b*`SNP_BYTE_W +: `SNP_BYTE_W], ADDR_PARITY[b]} == 1'b0);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            PARITY_ERROR <= 1'b0;
        end else begin
            PARITY_ERROR <= qualified && parity_bad;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (qualified && !parity_bad) begin
                    next_state = ST_LOOKUP;
                end
            end
            ST_LOOKUP: begin
                next_state = ST_RESPOND;
            end
            ST_RESPOND: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            LOOKUP_ADDR <= '0;
            snp_tt <= `SNP_TT_CLEAN;
            snp_single <= 1'b0;
            snp_busy <= 1'b0;
        end else if (state == ST_IDLE && qualified) begin
            LOOKUP_ADDR <= ADDR;
            snp_tt <= TRANSFER_TYPE;
            snp_single <= BURST_INDICATION_N;
            snp_busy <= SNOOP_BUSY;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            L1_LOOKUP <= 1'b0;
            L2_LOOKUP <= 1'b0;
        end else begin
            // Data tags only; there is no instruction cache port at all
            L1_LOOKUP <= state == ST_IDLE && qualified && !parity_bad;
            L2_LOOKUP <= state == ST_IDLE && qualified && !parity_bad;
        end
    end

    snoop_line_match #(
        .ENTRIES(FILL_ENTRIES)
    ) u_fill_match (
        .snoop_addr(LOOKUP_ADDR),
        .line_addr(FILL_ADDR),
        .line_valid(FILL_VALID),
        .hit(fill_hit)
    );

    snoop_line_match #(
        .ENTRIES(QUEUE_ENTRIES)
    ) u_queue_match (
        .snoop_addr(LOOKUP_ADDR),
        .line_addr(QUEUE_ADDR),
        .line_valid(QUEUE_PENDING),
        .hit(queue_hit)
    );

    assign is_kill = snp_tt == `SNP_TT_KILL;
    // Data reads carry read and data bits; kill and sync share the read bit but move no data
    assign is_read = snp_tt[`SNP_TT_READ_BIT] && !snp_tt[`SNP_TT_ADDR_ONLY_BIT] &&
        snp_tt[`SNP_TT_WRITE_BIT];
    assign cache_hit = L1_HIT || L2_HIT;
    assign cache_mod = (L1_HIT && L1_MODIFIED) || (L2_HIT && L2_MODIFIED);
    // Address-only broadcasts other than kill carry no coherency action
    assign no_action = snp_tt == `SNP_TT_CLEAN || snp_tt == `SNP_TT_FLUSH ||
        snp_tt == `SNP_TT_SYNC || snp_tt == `SNP_TT_BARRIER || snp_tt == `SNP_TT_ECOWX ||
        snp_tt == `SNP_TT_ECIWX || snp_tt == `SNP_TT_TLBIE || snp_tt == `SNP_TT_RSV_SET ||
        snp_tt == `SNP_TT_TLBSYNC || snp_tt == `SNP_TT_ICBI;
    // Kill on an exclusive line invalidates silently; a modified one must retry first
    assign want_retry = snp_busy || fill_hit || queue_hit ||
        (!no_action && cache_hit && (!is_kill || cache_mod));

    always_comb begin
        next_action = ACT_NONE;
        if (!no_action && cache_hit) begin
            if (cache_mod) begin
                next_action = ACT_PUSH;
            end else if (is_kill || (is_read && !snp_single) || !is_read) begin
                next_action = ACT_INVAL;
            end
        end
        // Single-beat reads are caching inhibited: leave a clean copy alone
        if (is_read && snp_single && !cache_mod) begin
            next_action = ACT_NONE;
        end
        if (snp_busy) begin
            next_action = ACT_NONE;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ADDRESS_RETRY_N <= 1'b1;
            CACHE_ACTION <= ACT_NONE;
            CACHE_ACTION_VALID <= 1'b0;
            RSV_CLEAR <= 1'b0;
        end else begin
            ADDRESS_RETRY_N <= !(state == ST_LOOKUP && want_retry);
            // A miss forwards nothing, so cache state is left as it was
            CACHE_ACTION <= state == ST_LOOKUP ? next_action : ACT_NONE;
            CACHE_ACTION_VALID <= state == ST_LOOKUP && next_action != ACT_NONE;
            RSV_CLEAR <= state == ST_LOOKUP && is_kill && RSV_VALID &&
                RSV_ADDR[`SNP_ADDR_W-1:`SNP_LINE_OFS] == LOOKUP_ADDR[`SNP_ADDR_W-1:`SNP_LINE_OFS];
        end
    end

    AST_QUAL_LOOKUP: assert property (@(posedge CLK) disable iff (!RESETN)
        (state == ST_IDLE && !TRANSFER_START_N && !GLOBAL_COHERENT_N && !OWN_TENURE && !parity_bad)
        |=> L1_LOOKUP && L2_LOOKUP)
        else $error("qualified snoop did not start tag lookup");
    AST_RSV_QUAL: assert property (@(posedge CLK) disable iff (!RESETN)
        (state == ST_IDLE && !TRANSFER_START_N && RSV_VALID && !OWN_TENURE && !parity_bad &&
         TRANSFER_TYPE == `SNP_TT_KILL) |=> L1_LOOKUP)
        else $error("kill under reservation was not snooped");
    AST_OWN_IGNORED: assert property (@(posedge CLK) disable iff (!RESETN)
        (state == ST_IDLE && OWN_TENURE) |=> !L1_LOOKUP ##1 ADDRESS_RETRY_N)
        else $error("own tenure was snooped");
    AST_PARITY_FLAG: assert property (@(posedge CLK) disable iff (!RESETN)
        (!TRANSFER_START_N && !GLOBAL_COHERENT_N && !OWN_TENURE && parity_bad) |=> PARITY_ERROR)
        else $error("parity error not reported");
    AST_NO_QUAL_NO_LOOKUP: assert property (@(posedge CLK) disable iff (!RESETN)
        (TRANSFER_START_N || (GLOBAL_COHERENT_N && !RSV_VALID)) |=> !L1_LOOKUP)
        else $error("unqualified snoop looked up");
    AST_COLLIDE_RETRY: assert property (@(posedge CLK) disable iff (!RESETN)
        (state == ST_LOOKUP && (fill_hit || queue_hit)) |=> !ADDRESS_RETRY_N)
        else $error("collision not retried");
    AST_HIT_RETRY: assert property (@(posedge CLK) disable iff (!RESETN)
        (L1_LOOKUP && cache_hit && !is_kill && !no_action) |=> !ADDRESS_RETRY_N)
        else $error("snoop hit not retried");
    AST_KILL_MOD: assert property (@(posedge CLK) disable iff (!RESETN)
        (L1_LOOKUP && is_kill && cache_mod && !snp_busy)
        |=> !ADDRESS_RETRY_N && CACHE_ACTION == ACT_PUSH && CACHE_ACTION_VALID)
        else $error("kill on modified line not pushed");
    AST_KILL_EXCL: assert property (@(posedge CLK) disable iff (!RESETN)
        (L1_LOOKUP && is_kill && cache_hit && !cache_mod && !snp_busy && !fill_hit && !queue_hit)
        |=> ADDRESS_RETRY_N && CACHE_ACTION == ACT_INVAL)
        else $error("kill on exclusive line not invalidated");
    AST_MISS_QUIET: assert property (@(posedge CLK) disable iff (!RESETN)
        (L1_LOOKUP && !cache_hit) |=> !CACHE_ACTION_VALID)
        else $error("miss changed cache state");
    AST_NOACT: assert property (@(posedge CLK) disable iff (!RESETN)
        (L1_LOOKUP && no_action && !fill_hit && !queue_hit && !snp_busy)
        |=> ADDRESS_RETRY_N && !CACHE_ACTION_VALID)
        else $error("no-action type caused a response");
    // Reservation, address capture, refusal, parity, read, busy and pulse-width guards
    AST_RSV_WRITE: assert property (@(posedge CLK) disable iff (!RESETN)
        (state == ST_IDLE && start && GLOBAL_COHERENT_N && RSV_VALID && !parity_bad &&
         !TRANSFER_TYPE[`SNP_TT_READ_BIT] && !TRANSFER_TYPE[`SNP_TT_ADDR_ONLY_BIT] && TRANSFER_TYPE[`SNP_TT_WRITE_BIT])
        |=> L1_LOOKUP && L2_LOOKUP)
        else $error("write under reservation was not snooped");
    AST_LOOKUP_ADDR: assert property (@(posedge CLK) disable iff (!RESETN)
        (state == ST_IDLE && qualified && !parity_bad)
        |=> LOOKUP_ADDR == $past(ADDR))
        else $error("lookup address not captured");
    AST_REFUSED: assert property (@(posedge CLK) disable iff (!RESETN)
        (state != ST_IDLE)
        |=> !L1_LOOKUP && !L2_LOOKUP)
        else $error("snoop taken while busy with another");
    AST_BAD_PAR_NO_LOOKUP: assert property (@(posedge CLK) disable iff (!RESETN)
        (state == ST_IDLE && qualified && parity_bad)
        |=> PARITY_ERROR && !L1_LOOKUP && !L2_LOOKUP)
        else $error("bad parity snoop looked up or not reported");
    AST_READ_FLUSH: assert property (@(posedge CLK) disable iff (!RESETN)
        (L1_LOOKUP && is_read && !snp_single && cache_hit && !snp_busy)
        |=> !ADDRESS_RETRY_N && CACHE_ACTION_VALID)
        else $error("burst read hit not flushed");
    AST_SINGLE_READ: assert property (@(posedge CLK) disable iff (!RESETN)
        (L1_LOOKUP && is_read && snp_single && !cache_mod)
        |=> !CACHE_ACTION_VALID)
        else $error("single-beat read changed a clean line");
    AST_BUSY_RETRY: assert property (@(posedge CLK) disable iff (!RESETN)
        (L1_LOOKUP && snp_busy)
        |=> !ADDRESS_RETRY_N && !CACHE_ACTION_VALID)
        else $error("busy snoop not retried");
    AST_RSV_KILL_ONLY: assert property (@(posedge CLK) disable iff (!RESETN)
        (state == ST_LOOKUP && !is_kill)
        |=> !RSV_CLEAR)
        else $error("reservation cleared by a non-kill type");
    AST_RETRY_PULSE: assert property (@(posedge CLK) disable iff (!RESETN)
        !ADDRESS_RETRY_N
        |=> ADDRESS_RETRY_N)
        else $error("retry held longer than one cycle");
    AST_ACTION_PULSE: assert property (@(posedge CLK) disable iff (!RESETN)
        CACHE_ACTION_VALID
        |=> !CACHE_ACTION_VALID && CACHE_ACTION == ACT_NONE)
        else $error("cache action held longer than one cycle");
endmodule : snoop_ctrl

/* test/snoop_cache_model.sv */
// Tag array stand-in: one line, answering L1 or L2 lookups for the snoop logic.
// Assumes answers are read only while the lookup strobe is high.
`timescale 1ns/10ps
module snoop_cache_model (
    input wire logic clk,
    input wire logic lookup,
    input wire logic [31:0] lookup_addr,
    input wire logic [31:0] line_addr,
    input wire logic [1:0] line_state,
    input wire logic in_l2,
    output logic l1_hit,
    output logic l1_mod,
    output logic l2_hit,
    output logic l2_mod
);
    logic tog = 1'b0;
    logic hit;
    logic md;
    // Outside a lookup the answers toggle, so a stale sample is never a stable match
    always @(posedge clk) tog <= ~tog;
    assign hit = lookup_addr[31:5] == line_addr[31:5] && line_state != 2'h0;
    assign md = hit && line_state == 2'h2;
    assign l1_hit = lookup ? hit && !in_l2 : tog;
    assign l1_mod = lookup ? md && !in_l2 : ~tog;
    assign l2_hit = lookup ? hit && in_l2 : tog;
    assign l2_mod = lookup ? md && in_l2 : ~tog;
endmodule : snoop_cache_model

/* test/data_cache_bus_snoop_logic_test.sv */
// Self-checking bench for snoop_ctrl with a one-line tag model on its lookup side.
// Assumes default entry counts: 2 fill slots and 4 queue slots.
`timescale 1ns/10ps
module data_cache_bus_snoop_logic_test;
    import snoop_pkg::*;
    logic CLK = 1'b0, RESETN = 1'b0, TRANSFER_START_N = 1'b1, GLOBAL_COHERENT_N = 1'b1;
    logic ADDRESS_BUS_BUSY_N = 1'b1, BURST_INDICATION_N = 1'b0, OWN_TENURE = 1'b0, SNOOP_BUSY = 1'b0;
    logic RSV_VALID = 1'b0, L1_HIT, L1_MODIFIED, L2_HIT, L2_MODIFIED, in_l2 = 1'b0;
    logic [4:0] TRANSFER_TYPE = 5'h00;
    logic [3:0] ADDR_PARITY = 4'h0;
    logic [31:0] ADDR = 32'h0, RSV_ADDR = 32'h0, LOOKUP_ADDR, line_addr = 32'h0, la;
    logic [63:0] FILL_ADDR = 64'h0;
    logic [1:0] FILL_VALID = 2'h0, CACHE_ACTION, line_state = 2'h0, act;
    logic [127:0] QUEUE_ADDR = 128'h0;
    logic [3:0] QUEUE_PENDING = 4'h0;
    logic L1_LOOKUP, L2_LOOKUP, ADDRESS_RETRY_N, CACHE_ACTION_VALID, RSV_CLEAR, PARITY_ERROR;
    logic lk, l2k, pe, rt, av, rc;
    logic address_ack_n = 1'b1;
    int bad_count = 0, cmp_count = 0;
    localparam logic [31:0] A = 32'h0001_2340;
    localparam logic [4:0] NOACT [10] = '{5'h00, 5'h04, 5'h08, 5'h10, 5'h14, 5'h1c, 5'h18, 5'h01, 5'h09, 5'h0d};
    always #4 CLK = ~CLK;
    snoop_ctrl snoop_ctrl_inst (.CLK(CLK), .RESETN(RESETN), .TRANSFER_START_N(TRANSFER_START_N),
        .GLOBAL_COHERENT_N(GLOBAL_COHERENT_N), .ADDRESS_BUS_BUSY_N(ADDRESS_BUS_BUSY_N),
        .BURST_INDICATION_N(BURST_INDICATION_N), .TRANSFER_TYPE(TRANSFER_TYPE), .ADDR(ADDR),
        .ADDR_PARITY(ADDR_PARITY), .OWN_TENURE(OWN_TENURE), .SNOOP_BUSY(SNOOP_BUSY), .RSV_VALID(RSV_VALID),
        .RSV_ADDR(RSV_ADDR), .L1_HIT(L1_HIT), .L1_MODIFIED(L1_MODIFIED), .L2_HIT(L2_HIT),
        .L2_MODIFIED(L2_MODIFIED), .FILL_ADDR(FILL_ADDR), .FILL_VALID(FILL_VALID), .QUEUE_ADDR(QUEUE_ADDR),
        .QUEUE_PENDING(QUEUE_PENDING), .LOOKUP_ADDR(LOOKUP_ADDR), .L1_LOOKUP(L1_LOOKUP), .L2_LOOKUP(L2_LOOKUP),
        .ADDRESS_RETRY_N(ADDRESS_RETRY_N), .CACHE_ACTION(CACHE_ACTION), .CACHE_ACTION_VALID(CACHE_ACTION_VALID),
        .RSV_CLEAR(RSV_CLEAR), .PARITY_ERROR(PARITY_ERROR));
    snoop_cache_model snoop_cache_model_inst (.clk(CLK), .lookup(L1_LOOKUP), .lookup_addr(LOOKUP_ADDR),
        .line_addr(line_addr), .line_state(line_state), .in_l2(in_l2), .l1_hit(L1_HIT), .l1_mod(L1_MODIFIED),
        .l2_hit(L2_HIT), .l2_mod(L2_MODIFIED));
    function automatic logic [3:0] par(input logic [31:0] a);
        for (int b = 0; b < 4; b++) begin
            par[b] = ~^a[8*b +: 8];
        end
    endfunction : par
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    // One tenure, foreign unless OWN_TENURE is set, a single start pulse and 3 cycles of spacing before the next
    task automatic snp(input logic [4:0] tt, input logic [31:0] a, input logic g_n, input logic pbad);
        @(posedge CLK);
        TRANSFER_START_N <= 1'b0;
        TRANSFER_TYPE <= tt;
        ADDR <= a;
        GLOBAL_COHERENT_N <= g_n;
        ADDR_PARITY <= par(a) ^ {3'h0, pbad};
        @(posedge CLK);
        TRANSFER_START_N <= 1'b1;
        address_ack_n <= 1'b0;
        #1;
        lk = L1_LOOKUP;
        l2k = L2_LOOKUP;
        la = LOOKUP_ADDR;
        pe = PARITY_ERROR;
        @(posedge CLK);
        address_ack_n <= 1'b1;
        #1;
        rt = ADDRESS_RETRY_N;
        act = CACHE_ACTION;
        av = CACHE_ACTION_VALID;
        rc = RSV_CLEAR;
        @(posedge CLK);
    endtask : snp
    task automatic t_kill;
        line_addr = A;
        line_state = 2'h1;
        RSV_VALID <= 1'b1;
        RSV_ADDR <= A + 32'h8;
        ADDRESS_BUS_BUSY_N <= 1'b0;
        snp(5'h0c, A, 1'b0, 1'b0);
        chk(lk === 1'b1 && l2k === 1'b1 && la === A, "lookup strobes or address");
        chk(rt === 1'b1 && av === 1'b1 && act === ACT_INVAL && rc === 1'b1, "kill exclusive");
        line_state = 2'h2;
        snp(5'h0c, A + 32'h1c, 1'b0, 1'b0);
        chk(rt === 1'b0 && av === 1'b1 && act === ACT_PUSH, "kill modified");
        line_state = 2'h0;
        snp(5'h0c, A, 1'b1, 1'b0);
        chk(lk === 1'b1 && rt === 1'b1 && rc === 1'b1, "reserved kill without coherence");
        chk(av !== 1'b1 || act === ACT_NONE, "kill miss changed state");
        snp(5'h02, A, 1'b1, 1'b0);
        chk(lk === 1'b1 && rt === 1'b1 && rc === 1'b0, "reserved write without coherence");
        snp(5'h0c, A + 32'h20, 1'b1, 1'b0);
        chk(lk === 1'b1 && rt === 1'b1 && rc === 1'b0, "kill cleared other line");
        RSV_VALID <= 1'b0;
        ADDRESS_BUS_BUSY_N <= 1'b1;
        $display("kill test done");
    endtask : t_kill
    task automatic t_other;
        line_state = 2'h1;
        in_l2 = 1'b1;
        snp(5'h02, A, 1'b0, 1'b0);
        chk(rt === 1'b0 && av === 1'b1 && act === ACT_INVAL, "clean l2 hit");
        line_state = 2'h2;
        snp(5'h02, A, 1'b0, 1'b0);
        chk(rt === 1'b0 && av === 1'b1 && act === ACT_PUSH, "modified l2 hit");
        snp(5'h02, A, 1'b1, 1'b0);
        chk(lk === 1'b0 && rt === 1'b1, "unqualified snoop");
        OWN_TENURE <= 1'b1;
        snp(5'h02, A, 1'b0, 1'b0);
        chk(lk === 1'b0 && rt === 1'b1, "own tenure snooped");
        OWN_TENURE <= 1'b0;
        line_state = 2'h1;
        snp(5'h0a, A, 1'b0, 1'b0);
        chk(rt === 1'b0 && av === 1'b1 && act === ACT_INVAL, "burst read clean hit");
        BURST_INDICATION_N <= 1'b1;
        snp(5'h0a, A, 1'b0, 1'b0);
        chk(rt === 1'b0 && av === 1'b0 && act === ACT_NONE, "single-beat read acted");
        BURST_INDICATION_N <= 1'b0;
        in_l2 = 1'b0;
        $display("other types test done");
    endtask : t_other
    task automatic t_noact;
        line_state = 2'h2;
        foreach (NOACT[i]) begin
            snp(NOACT[i], A, 1'b0, 1'b0);
            chk(rt === 1'b1 && (av !== 1'b1 || act === ACT_NONE), "no-action type acted");
        end
        line_state = 2'h0;
        $display("no-action test done");
    endtask : t_noact
    task automatic t_coll;
        FILL_ADDR <= {A + 32'h14, 32'h0};
        FILL_VALID <= 2'h2;
        snp(5'h02, A, 1'b0, 1'b0);
        chk(rt === 1'b0, "fill collision");
        snp(5'h02, A + 32'h20, 1'b0, 1'b0);
        chk(rt === 1'b1, "next line collided");
        FILL_VALID <= 2'h0;
        QUEUE_ADDR <= {32'h0, A + 32'h4, 64'h0};
        QUEUE_PENDING <= 4'h4;
        snp(5'h02, A, 1'b0, 1'b0);
        chk(rt === 1'b0, "queue collision");
        QUEUE_PENDING <= 4'h0;
        snp(5'h02, A, 1'b0, 1'b0);
        chk(rt === 1'b1, "granted queue entry collided");
        SNOOP_BUSY <= 1'b1;
        snp(5'h02, A, 1'b0, 1'b0);
        chk(rt === 1'b0, "busy retry");
        SNOOP_BUSY <= 1'b0;
        snp(5'h02, A, 1'b0, 1'b0);
        chk(rt === 1'b1, "reissued snoop retried");
        $display("collision test done");
    endtask : t_coll
    task automatic t_par;
        snp(5'h02, A, 1'b0, 1'b1);
        chk(pe === 1'b1 && lk === 1'b0, "bad parity");
        snp(5'h02, A, 1'b0, 1'b0);
        chk(pe === 1'b0, "false parity error");
        $display("parity test done");
    endtask : t_par
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (5) @(posedge CLK);
        RESETN <= 1'b1;
        t_kill();
        t_other();
        t_noact();
        t_coll();
        t_par();
        close_out();
    end
endmodule : data_cache_bus_snoop_logic_test
